// File: inc/wdd_pkg.sv
package wdd_pkg;
  // Serial shift register layout and reset value
  localparam int              WDD_SSR_W        = 7;
  localparam logic [6:0]      WDD_SSR_RESET    = 7'h40;
  // Wiper code layout and decode window
  localparam int              WDD_WIPER_W      = 7;
  localparam logic [6:0]      WDD_WIN_LOW      = 7'h20;
  localparam logic [6:0]      WDD_WIN_HIGH     = 7'h60;
  localparam logic [6:0]      WDD_WIPER_ZERO   = 7'h00;
  localparam logic [6:0]      WDD_WIPER_FULL   = 7'h40;
  // Command code that selects the shift register
  localparam logic [7:0]      WDD_CMD_SSR      = 8'h00;
  // Device address, arbitrary value
  localparam logic [6:0]      WDD_DEV_ADDR     = 7'h2E;
  // Bits in a byte, counter layout
  localparam logic [3:0]      WDD_BYTE_BITS    = 4'h8;

  // Serial bus states
  typedef enum logic [5:0] {
    WDD_IDLE = 6'b00_0001,
    WDD_RECV = 6'b00_0010,
    WDD_RACK = 6'b00_0100,
    WDD_SEND = 6'b00_1000,
    WDD_SACK = 6'b01_0000,
    WDD_SKIP = 6'b10_0000
  } wdd_state_t;

  // Synchronised and edge-detected bus lines
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } wdd_bus_ev_t;
endpackage : wdd_pkg

// File: verilog/wdd_decoder.sv
`timescale 1ns/1ps
module wdd_decoder (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  output logic [6:0]       WIPER_OUT,
  output logic [6:0]       SERIAL_SHIFT_VALUE_OUT
);
  import wdd_pkg::*;

  // Two-stage synchronisers, then one history stage for edges
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  wdd_bus_ev_t ev;

  // Sample the bus lines on the core clock
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], SCL_IN};
      sda_sync_q <= {sda_sync_q[0], SDA_IN};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Edge and condition decode, only from the second stage onward
  always_comb begin
    ev.scl_rise = scl_sync_q[1] & ~scl_prev_q;
    ev.scl_fall = ~scl_sync_q[1] & scl_prev_q;
    ev.start    = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    ev.stop     = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
    ev.sda      = sda_sync_q[1];
  end

  // Protocol state
  wdd_state_t  st_q, st_d;
  logic [3:0]  bit_q, bit_d;         // Bits handled in current byte
  logic [7:0]  shf_q, shf_d;         // Byte shifter
  logic [1:0]  idx_q, idx_d;         // Byte index: 0 addr, 1 cmd, 2+ data
  logic        rd_q, rd_d;           // Current frame is a read
  logic        cmd_ok_q, cmd_ok_d;   // Last command code was zero
  logic [6:0]  ssr_q, ssr_d;         // Serial shift register
  logic [6:0]  pend_q, pend_d;       // Byte waiting for its ack to end
  logic        pend_v_q, pend_v_d;   // Pending byte is to be committed
  logic        sda_o_q, sda_o_d;     // Pin drive level
  logic        sda_e_q, sda_e_d;     // Pin drive enable
  logic        commit;               // Ack falling edge of a data byte

  // Next-state logic for the serial protocol
  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    shf_d    = shf_q;
    idx_d    = idx_q;
    rd_d     = rd_q;
    cmd_ok_d = cmd_ok_q;
    ssr_d    = ssr_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    sda_o_d  = sda_o_q;
    sda_e_d  = sda_e_q;
    commit   = 1'b0;
    if (ev.start) begin
      // Start or restart: a byte in flight is dropped
      // drop cut byte
      st_d     = WDD_RECV;
      bit_d    = 4'h0;
      idx_d    = 2'h0;
      pend_v_d = 1'b0;
      sda_e_d  = 1'b0;
    end else if (ev.stop) begin
      st_d     = WDD_IDLE;
      pend_v_d = 1'b0;
      sda_e_d  = 1'b0;
    end else begin
      case (st_q)
        WDD_IDLE: begin
          sda_e_d = 1'b0;
        end
        WDD_RECV: begin
          if (ev.scl_rise) begin
            shf_d = {shf_q[6:0], ev.sda};
            bit_d = bit_q + 4'h1;
          end else if (ev.scl_fall && bit_q == WDD_BYTE_BITS) begin
            bit_d = 4'h0;
            st_d  = WDD_RACK;
            sda_o_d = 1'b0;
            sda_e_d = 1'b1;
            if (idx_q == 2'h0) begin
              if (shf_q[7:1] == WDD_DEV_ADDR) begin
                rd_d = shf_q[0];
              end else begin
                st_d    = WDD_SKIP;
                sda_e_d = 1'b0;
              end
            end else if (idx_q == 2'h1) begin
              cmd_ok_d = (shf_q == WDD_CMD_SSR);
            end else begin
              pend_d   = shf_q[6:0];
              pend_v_d = cmd_ok_q;
            end
          end
        end
        WDD_RACK: begin
          if (ev.scl_fall) begin
            sda_e_d = 1'b0;
            if (pend_v_q) begin
              commit = 1'b1;
              ssr_d  = pend_q;
            end
            pend_v_d = 1'b0;
            if (idx_q != 2'h2) begin
              idx_d = idx_q + 2'h1;
            end
            if (idx_q == 2'h0 && rd_q) begin
              st_d = cmd_ok_q ? WDD_SEND : WDD_SKIP;
              shf_d   = {1'b0, ssr_q};
              sda_o_d = 1'b0;
              sda_e_d = cmd_ok_q;
              bit_d   = 4'h1;
            end else begin
              st_d = WDD_RECV;
            end
          end
        end
        WDD_SEND: begin
          if (ev.scl_fall) begin
            if (bit_q == WDD_BYTE_BITS) begin
              sda_e_d = 1'b0;
              st_d    = WDD_SACK;
            end else begin
              sda_o_d = shf_q[3'(4'h7 - bit_q)];
              bit_d   = bit_q + 4'h1;
            end
          end
        end
        WDD_SACK: begin
          if (ev.scl_rise) begin
            st_d = ev.sda ? WDD_SKIP : WDD_SACK;
          end else if (ev.scl_fall) begin
            shf_d   = {1'b0, ssr_q};
            sda_o_d = 1'b0;
            sda_e_d = 1'b1;
            bit_d   = 4'h1;
            st_d    = WDD_SEND;
          end
        end
        WDD_SKIP: begin
          sda_e_d = 1'b0;
        end
        default: begin
          st_d    = WDD_IDLE;
          sda_e_d = 1'b0;
        end
      endcase
    end
  end

  // Protocol registers
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q     <= WDD_IDLE;
      bit_q    <= 4'h0;
      shf_q    <= 8'h00;
      idx_q    <= 2'h0;
      rd_q     <= 1'b0;
      cmd_ok_q <= 1'b0;
      ssr_q    <= WDD_SSR_RESET;
      pend_q   <= 7'h00;
      pend_v_q <= 1'b0;
      sda_o_q  <= 1'b1;
      sda_e_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      shf_q    <= shf_d;
      idx_q    <= idx_d;
      rd_q     <= rd_d;
      cmd_ok_q <= cmd_ok_d;
      ssr_q    <= ssr_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      sda_o_q  <= sda_o_d;
      sda_e_q  <= sda_e_d;
    end
  end

  // Window decode; purely combinational so the wiper follows the register
  // clamp low
  always_comb begin
    if (ssr_q <= WDD_WIN_LOW) begin
      WIPER_OUT = WDD_WIPER_ZERO;
    end else if (ssr_q >= WDD_WIN_HIGH) begin
      WIPER_OUT = WDD_WIPER_FULL;
    end else begin
      WIPER_OUT = ssr_q - WDD_WIN_LOW;
    end
  end

  assign SERIAL_SHIFT_VALUE_OUT = ssr_q;
  assign SDA_OUT                = sda_o_q;
  assign SDA_OE_OUT             = sda_e_q;

  // Properties
  property p_range;
    @(posedge CORE_CLK_IN) disable iff (RST_IN) WIPER_OUT <= WDD_WIPER_FULL;
  endproperty
  a_range: assert property (p_range) else $error("wiper above 64");
  property p_low;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      ssr_q <= 7'h20 |-> WIPER_OUT == 7'h00;
  endproperty
  a_low: assert property (p_low) else $error("low clamp wrong");
  property p_mid;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (ssr_q > 7'h20 && ssr_q < 7'h60) |-> WIPER_OUT + 7'h20 == ssr_q;
  endproperty
  a_mid: assert property (p_mid) else $error("offset wrong");
  property p_high;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      ssr_q >= 7'h60 |-> WIPER_OUT == 7'h40;
  endproperty
  a_high: assert property (p_high) else $error("high clamp wrong");
  property p_center;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      ssr_q == 7'h40 |-> WIPER_OUT == 7'h20;
  endproperty
  a_center: assert property (p_center) else $error("mid wrong");
  property p_only_commit;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !$past(commit) |-> $stable(ssr_q);
  endproperty
  a_only_commit: assert property (p_only_commit) else $error("stray update");
  property p_commit_edge;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      commit |-> sda_e_q && !sda_o_q && scl_prev_q && !scl_sync_q[1];
  endproperty
  a_commit_edge: assert property (p_commit_edge) else $error("bad commit");
  property p_cmd_gate;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      commit |-> cmd_ok_q;
  endproperty
  a_cmd_gate: assert property (p_cmd_gate) else $error("cmd not zero");
  property p_msb_zero;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (st_q == WDD_SEND && bit_q == 4'h1) |-> !sda_o_q;
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("msb not zero");
  property p_start_drop;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (ev.start || ev.stop) |=> !pend_v_q;
  endproperty
  a_start_drop: assert property (p_start_drop) else $error("cut byte kept");
  c_commit: cover property (@(posedge CORE_CLK_IN) commit);
  c_read:   cover property (@(posedge CORE_CLK_IN) st_q == WDD_SEND);
  c_full:   cover property (@(posedge CORE_CLK_IN) WIPER_OUT == 7'h40);
  c_ack_rd: cover property (@(posedge CORE_CLK_IN) st_q == WDD_SACK && ev.scl_fall);
  // A refused frame must leave the line to the pull-up
  // skip stays quiet
  property p_skip_quiet;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      st_q == WDD_SKIP |-> !sda_e_q;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("drives in skip");
endmodule : wdd_decoder

// File: test/wdd_i2c_master.sv
`timescale 1ns/1ps
// Bus master model; SCL rests high between frames, SDA is open-drain
module wdd_i2c_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end
  // Whole core cycles, so every change lands just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // One bit: data moves mid-low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_low_out <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(3);
    r = sda_in;
    tick(1);
    scl_out <= 1'b0;
  endtask : bit_io
  // Start or repeated start: data falls while clock is high
  task automatic start();
    tick(2);
    sda_low_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask : start
  // Stop: data rises while clock is high, then the bus rests
  task automatic stop();
    tick(2);
    sda_low_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b0;
    tick(4);
  endtask : stop
  // Byte MSB first plus the ninth bit; returns what the bus showed
  task automatic xfer(input logic [7:0] d, input logic a_in,
                      output logic [7:0] q, output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, a_out);
  endtask : xfer
endmodule : wdd_i2c_master

// File: test/test_wdd_decoder.sv
`timescale 1ns/1ps
module test_wdd_decoder;
  import wdd_pkg::*;
  logic       clk, rst, scl, sda_low, sda_out, sda_oe, sda_bus;
  logic [6:0] wiper, serial_shift_value;
  int         errors = 0;
  int         num_checks = 0;
  // Pull-up wire: low while either party pulls it down
  assign sda_bus = ~(sda_low | (sda_oe & ~sda_out));
  wdd_decoder dut (.CORE_CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl),
    .SDA_IN(sda_bus), .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
    .WIPER_OUT(wiper), .SERIAL_SHIFT_VALUE_OUT(serial_shift_value));
  wdd_i2c_master host (.clk_in(clk), .sda_in(sda_bus), .scl_out(scl),
    .sda_low_out(sda_low));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Expected wiper from the clamped window
  function automatic logic [6:0] dec(input logic [6:0] s);
    if (s <= 7'h20) return 7'h00;
    if (s >= 7'h60) return 7'h40;
    return s - 7'h20;
  endfunction : dec
  // Single-byte write frame; returns the data byte acknowledge
  task automatic wr(input logic [6:0] adr, input logic [7:0] cmd,
                    input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic       a;
    host.start();
    host.xfer({adr, 1'b0}, 1'b1, q, a);
    host.xfer(cmd, 1'b1, q, a);
    host.xfer(d, 1'b1, q, ack);
    host.stop();
  endtask : wr
  // Command write, repeated start, one byte read, master declines more
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
    logic [7:0] q;
    logic       a;
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host.xfer(cmd, 1'b1, q, a);
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b1}, 1'b1, q, a);
    host.xfer(8'hFF, 1'b1, d, a);
    host.stop();
  endtask : rd
  task automatic t_reset();
    chk("ssr", 8'h40, {1'b0, serial_shift_value});
    chk("wiper", 8'h20, {1'b0, wiper});
    chk("oe", 8'h00, {7'h00, sda_oe});
    $display("reset values done");
  endtask : t_reset
  // Every window region, both ends, top bit set and clear
  task automatic t_decode();
    logic [7:0] v [10] = '{8'h00, 8'h20, 8'hA1, 8'h21, 8'h40, 8'hC0,
                           8'h5F, 8'h60, 8'h7F, 8'hFF};
    logic [7:0] r;
    logic       a;
    foreach (v[i]) begin
      wr(WDD_DEV_ADDR, 8'h00, v[i], a);
      chk("ack", 8'h00, {7'h00, a});
      chk("ssr", {1'b0, v[i][6:0]}, {1'b0, serial_shift_value});
      chk("wiper", {1'b0, dec(v[i][6:0])}, {1'b0, wiper});
      rd(8'h00, r);
      chk("read", {1'b0, v[i][6:0]}, r);
    end
    $display("decode table done");
  endtask : t_decode
  // Two data bytes in one frame, each committed at its acknowledge
  task automatic t_commit();
    logic [7:0] q;
    logic       a;
    wr(WDD_DEV_ADDR, 8'h00, 8'h50, a);
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host.xfer(8'h00, 1'b1, q, a);
    // FEh bit by bit, so the wiper is seen before the ack
    for (int i = 7; i >= 0; i--) host.bit_io(i != 0, q[i]);
    chk("wiper held", 8'h30, {1'b0, wiper});
    host.bit_io(1'b1, a);
    chk("ack 1st", 8'h00, {7'h00, a});
    chk("ssr at ack", 8'h50, {1'b0, serial_shift_value});
    host.tick(6);
    chk("ssr", 8'h7E, {1'b0, serial_shift_value});
    chk("wiper", 8'h40, {1'b0, wiper});
    host.xfer(8'h35, 1'b1, q, a);
    host.tick(6);
    chk("wiper 2nd", 8'h15, {1'b0, wiper});
    host.stop();
    $display("commit timing done");
  endtask : t_commit
  // Refused command, foreign address and a cut byte all leave 45h
  task automatic t_refuse();
    logic [7:0] r;
    logic [7:0] q;
    logic       a;
    wr(WDD_DEV_ADDR, 8'h00, 8'h45, a);
    wr(WDD_DEV_ADDR, 8'h01, 8'h7F, a);
    chk("ssr cmd", 8'h45, {1'b0, serial_shift_value});
    rd(8'h01, r);
    chk("read cmd", 8'hFF, r);
    wr(WDD_DEV_ADDR ^ 7'h01, 8'h00, 8'h7F, a);
    chk("ack addr", 8'h01, {7'h00, a});
    chk("ssr addr", 8'h45, {1'b0, serial_shift_value});
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host.xfer(8'h00, 1'b1, q, a);
    // First byte cut by a repeated start, the second by a stop
    for (int i = 0; i < 4; i++) host.bit_io(1'b1, a);
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host.xfer(8'h00, 1'b1, q, a);
    for (int i = 0; i < 4; i++) host.bit_io(1'b1, a);
    host.stop();
    chk("ssr cut", 8'h45, {1'b0, serial_shift_value});
    chk("wiper cut", 8'h25, {1'b0, wiper});
    $display("refusals done");
  endtask : t_refuse
  // Master acknowledges the read byte, so the device sends it again
  task automatic t_ack_read();
    logic [7:0] q;
    logic [7:0] d;
    logic       a;
    wr(WDD_DEV_ADDR, 8'h00, 8'hBB, a);
    chk("wiper", 8'h1B, {1'b0, wiper});
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host.xfer(8'h00, 1'b1, q, a);
    host.start();
    host.xfer({WDD_DEV_ADDR, 1'b1}, 1'b1, q, a);
    chk("ack rd", 8'h00, {7'h00, a});
    host.xfer(8'hFF, 1'b0, d, a);
    chk("read 1st", 8'h3B, d);
    host.xfer(8'hFF, 1'b1, d, a);
    chk("read 2nd", 8'h3B, d);
    host.stop();
    chk("ssr read", 8'h3B, {1'b0, serial_shift_value});
    $display("acknowledged read done");
  endtask : t_ack_read
  task automatic t_rst();
    rst <= 1'b1;
    host.tick(2);
    rst <= 1'b0;
    host.tick(3);
    t_reset();
  endtask : t_rst
  // Watchdog well beyond the roughly 8300 cycles the tests need
  initial begin
    #5_000_000;
    errors++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    host.tick(2);
    rst <= 1'b0;
    host.tick(3);
    t_reset();
    t_decode();
    t_commit();
    t_ack_read();
    t_refuse();
    t_rst();
    stop_test();
  end
endmodule : test_wdd_decoder
